// ==== inc/gmii_port_pkg.sv ====
// Shared constants, bundles, modes and decoders for the MAC data port
package gmii_port_pkg;

   localparam int CLK_KHZ = 10000;
   // Link clocks are modelled slowed down by this factor so the core clock can make them
   localparam int SLOWDOWN = 100;
   localparam int GIG_KHZ = 125000;
   localparam int FAST_KHZ = 25000;
   localparam int SER_KHZ = 10000;
   localparam int NIB_KHZ = 2500;
   localparam int RBC_KHZ = 62500;
   localparam int FAST_HIGH_PCT = 35;

   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] GIG_PER = CNT_W'(CLK_KHZ * SLOWDOWN / GIG_KHZ);
   localparam logic [CNT_W-1:0] FAST_PER = CNT_W'(CLK_KHZ * SLOWDOWN / FAST_KHZ);
   localparam logic [CNT_W-1:0] SER_PER = CNT_W'(CLK_KHZ * SLOWDOWN / SER_KHZ);
   localparam logic [CNT_W-1:0] NIB_PER = CNT_W'(CLK_KHZ * SLOWDOWN / NIB_KHZ);
   localparam logic [CNT_W-1:0] RBC_PER = CNT_W'(CLK_KHZ * SLOWDOWN / RBC_KHZ);
   localparam logic [CNT_W-1:0] FAST_HIGH =
      CNT_W'(CLK_KHZ * SLOWDOWN / FAST_KHZ * FAST_HIGH_PCT / 100);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [6:0] COMMA_POS = 7'h7C;
   localparam logic [6:0] COMMA_NEG = 7'h03;

   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] TXW_OFS = 12'h008;
   localparam logic [ADDR_W-1:0] RXW_OFS = 12'h00C;
   localparam logic [3:0] CTRL_RST = 4'h2;
   localparam int CTRL_SER_BIT = 2;
   localparam int CTRL_TBI_BIT = 3;
   localparam int ST_TXP = 0;
   localparam int ST_RXF = 1;
   localparam int ST_OVR = 2;
   localparam int ST_COL = 3;
   localparam int ST_CRS = 4;
   localparam int WORD_EN = 8;
   localparam int WORD_ER = 9;

   typedef enum logic [2:0] {MODE_GIG, MODE_FAST, MODE_NIB, MODE_SER, MODE_TBI} mode_t;

   typedef struct packed {
      logic       manual;
      logic       fdx;
      logic [1:0] spd;
      logic       ser;
      logic       tbi;
   } strap_t;

   typedef struct packed {
      logic       gtx;
      logic       er;
      logic       en;
      logic [7:0] txd;
   } dev_in_t;

   typedef struct packed {
      logic       tx_clk;
      logic       rx_clk;
      logic       col;
      logic       crs;
      logic       er;
      logic       dv;
      logic [7:0] rxd;
   } mac_in_t;

   function automatic mode_t mode_of(input logic tbi, input logic ser, input logic [1:0] spd);
      mode_t m;
      m = MODE_GIG;
      if (tbi)
         m = MODE_TBI;
      else if (spd == SPD_100)
         m = MODE_FAST;
      else if (spd == SPD_10)
         m = ser ? MODE_SER : MODE_NIB;
      return m;
   endfunction

   function automatic logic [CNT_W-1:0] rx_per(input mode_t m);
      logic [CNT_W-1:0] p;
      p = GIG_PER;
      unique case (m)
         MODE_GIG:  p = GIG_PER;
         MODE_FAST: p = FAST_PER;
         MODE_NIB:  p = NIB_PER;
         MODE_SER:  p = SER_PER;
         MODE_TBI:  p = RBC_PER;
      endcase
      return p;
   endfunction

   function automatic logic [CNT_W-1:0] rx_high(input mode_t m);
      return (m == MODE_FAST) ? FAST_HIGH : (rx_per(m) >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] tx_per(input mode_t m);
      return (m == MODE_NIB) ? NIB_PER : ((m == MODE_SER) ? SER_PER : FAST_PER);
   endfunction

   function automatic logic [7:0] mask_data(input mode_t m, input logic [7:0] d);
      logic [7:0] r;
      r = d;
      if (m == MODE_FAST || m == MODE_NIB)
         r = {4'h0, d[3:0]};
      else if (m == MODE_SER)
         r = {7'h00, d[0]};
      return r;
   endfunction

   function automatic logic is_comma(input logic [6:0] c);
      return (c == COMMA_POS) || (c == COMMA_NEG);
   endfunction

endpackage

// ==== inc/gmii_link_if.sv ====
// MAC data port wires between the transceiver end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface gmii_link_if;
   logic [7:0] txd;
   logic       tx_en;
   logic       tx_er;
   logic       gtx_clk;
   logic       tx_clk;
   logic [7:0] rxd;
   logic       rx_dv;
   logic       rx_er;
   logic       rx_clk;
   logic       col;
   logic       crs;

   modport dev (
      input  txd, tx_en, tx_er, gtx_clk,
      output tx_clk, rxd, rx_dv, rx_er, rx_clk, col, crs
   );

   modport mac (
      output txd, tx_en, tx_er, gtx_clk,
      input  tx_clk, rxd, rx_dv, rx_er, rx_clk, col, crs
   );
endinterface
`default_nettype wire

// ==== logic/gmii_phy_end.sv ====
// Transceiver end of the MAC data port: strap capture, link clocks, tx sampling, rx drive
// Functional notes
// - Tx data width follows 1000, nibble, serial
// - Controller asserts tx enable exactly with data
// - Tx clock 25, 2.5 or 10 MHz
// - Gigabit tx inputs sampled on controller clock
// - Tx error sends error symbols at 1000/100
// - Half-duplex 1000 tx error makes extension
// - Rx data width follows mode, unused lines low
// - Rx valid marks valid rx data
// - Rx error on error/extension, never at 10
// - Rx clock rate per mode, 35/65 at 100
// - Collision asynchronous, low in full duplex
// - Carrier sense follows line activity
// - Ten-bit tx code groups on gigabit clock
// - Ten-bit mode keeps 25 MHz utility clock
// - Ten-bit rx code groups on byte clocks
// - Two byte clocks, half period apart
// - Comma indicator toggles per comma found
// - Reset-latched inputs captured once at release
// - Manual inputs latched at release, later honoured only while select high
// - Ten-bit select chooses ten-bit configuration
// - Serial select picks 10 Mbps serial or nibble
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gmii_phy_end (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   gmii_link_if.dev        link,
   input  wire logic       ten_bit_select_i,
   input  wire logic       ten_meg_serial_select_i,
   input  wire logic       manual_select_i,
   input  wire logic [1:0] speed_select_i,
   input  wire logic       full_duplex_select_i,
   input  wire logic       line_rx_valid_i,
   input  wire logic [9:0] line_rx_data_i,
   input  wire logic       line_rx_err_i,
   input  wire logic       line_rx_ext_i,
   output logic            line_rx_take_o,
   input  wire logic       line_collision_i,
   input  wire logic       line_activity_i,
   output logic            line_tx_valid_o,
   output logic [9:0]      line_tx_data_o,
   output logic            line_tx_err_o,
   output logic            line_tx_ext_o
);

   typedef struct packed {
      logic [1:0]                           rel_cnt;
      logic                                 done;
      gmii_port_pkg::strap_t                strap_s1;
      gmii_port_pkg::strap_t                strap_s2;
      gmii_port_pkg::strap_t                strap_s3;
      logic                                 tbi;
      logic                                 ser;
      logic [1:0]                           spd;
      logic                                 fdx;
      gmii_port_pkg::dev_in_t               tx_s1;
      gmii_port_pkg::dev_in_t               tx_s2;
      gmii_port_pkg::dev_in_t               tx_s3;
      logic                                 gtx_lvl;
      logic [gmii_port_pkg::CNT_W-1:0]      rx_cnt;
      logic [gmii_port_pkg::CNT_W-1:0]      tx_cnt;
      logic [7:0]                           rxd;
      logic                                 dv;
      logic                                 er;
      logic                                 comma;
      logic [9:0]                           tx_data;
      logic                                 tx_valid;
      logic                                 tx_err;
      logic                                 tx_ext;
   } state_t;

   state_t                                  st_q;
   state_t                                  st_d;
   gmii_port_pkg::mode_t                    mode;
   logic [gmii_port_pkg::CNT_W-1:0]         rx_per;
   logic [gmii_port_pkg::CNT_W-1:0]         rx_hi;
   logic [gmii_port_pkg::CNT_W-1:0]         tx_per;
   logic                                    gig_clocked;
   logic                                    rx_upd;
   logic                                    gtx_rise;
   logic                                    tx_smp;
   logic                                    rbc1_lvl;
   logic                                    cnt_wrap;

   assign mode = gmii_port_pkg::mode_of(st_q.tbi, st_q.ser, st_q.spd);
   assign rx_per = gmii_port_pkg::rx_per(mode);
   assign rx_hi = gmii_port_pkg::rx_high(mode);
   assign tx_per = gmii_port_pkg::tx_per(mode);
   assign gig_clocked = (mode == gmii_port_pkg::MODE_GIG) || (mode == gmii_port_pkg::MODE_TBI);
   // Manual speed changes wait until both link clocks end a period, so no phase is cut short
   assign cnt_wrap = (st_q.rx_cnt >= rx_per - gmii_port_pkg::CNT_ONE)
                  && (st_q.tx_cnt >= tx_per - gmii_port_pkg::CNT_ONE);

   // Rx lines change at the rx clock's falling edge, or midway between the two byte clocks' rising edges in ten-bit mode
   assign rx_upd = st_q.done && (st_q.tbi ?
      (st_q.rx_cnt == (rx_hi >> 1) || st_q.rx_cnt == rx_hi + (rx_hi >> 1)) :
      (st_q.rx_cnt == rx_hi));

   // A gigabit clock edge counts only once two synchroniser stages agree
   assign gtx_rise = (st_q.tx_s2.gtx == st_q.tx_s3.gtx) && st_q.tx_s3.gtx && !st_q.gtx_lvl;
   assign tx_smp = st_q.done && (gig_clocked ? gtx_rise : (st_q.tx_cnt == '0));

   always_comb
   begin
      st_d = st_q;
      st_d.strap_s1 = {manual_select_i, full_duplex_select_i, speed_select_i,
                       ten_meg_serial_select_i, ten_bit_select_i};
      st_d.strap_s2 = st_q.strap_s1;
      st_d.strap_s3 = st_q.strap_s2;
      st_d.tx_s1 = {link.gtx_clk, link.tx_er, link.tx_en, link.txd};
      st_d.tx_s2 = st_q.tx_s1;
      st_d.tx_s3 = st_q.tx_s2;
      st_d.tx_valid = 1'b0;
      st_d.tx_ext = 1'b0;
      if (st_q.tx_s2.gtx == st_q.tx_s3.gtx)
         st_d.gtx_lvl = st_q.tx_s3.gtx;

      // Straps settle through the synchroniser before they are taken
      if (!st_q.done)
      begin
         if (st_q.rel_cnt == gmii_port_pkg::STRAP_WAIT)
         begin
            st_d.done = 1'b1;
            st_d.tbi = st_q.strap_s3.tbi;
            st_d.ser = st_q.strap_s3.ser;
            st_d.spd = st_q.strap_s3.spd;
            st_d.fdx = st_q.strap_s3.fdx;
         end
         else
            st_d.rel_cnt = st_q.rel_cnt + 2'h1;
      end
      else if (st_q.strap_s2 == st_q.strap_s3 && st_q.strap_s3.manual && cnt_wrap)
      begin
         st_d.spd = st_q.strap_s3.spd;
         st_d.fdx = st_q.strap_s3.fdx;
      end

      if (st_q.done)
      begin
         st_d.rx_cnt = (st_q.rx_cnt >= rx_per - gmii_port_pkg::CNT_ONE) ?
                       '0 : st_q.rx_cnt + gmii_port_pkg::CNT_ONE;
         st_d.tx_cnt = (st_q.tx_cnt >= tx_per - gmii_port_pkg::CNT_ONE) ?
                       '0 : st_q.tx_cnt + gmii_port_pkg::CNT_ONE;
      end

      if (rx_upd)
      begin
         if (st_q.tbi)
         begin
            {st_d.rxd, st_d.dv, st_d.er} = line_rx_data_i;
            if (gmii_port_pkg::is_comma(line_rx_data_i[9:3]))
               st_d.comma = !st_q.comma;
         end
         else
         begin
            st_d.dv = line_rx_valid_i;
            st_d.rxd = (line_rx_valid_i || line_rx_ext_i) ?
                       gmii_port_pkg::mask_data(mode, line_rx_data_i[7:0]) : 8'h00;
            st_d.er = ((mode == gmii_port_pkg::MODE_GIG) && (line_rx_err_i || line_rx_ext_i))
                   || ((mode == gmii_port_pkg::MODE_FAST) && line_rx_err_i);
         end
      end

      if (tx_smp)
      begin
         if (st_q.tbi)
         begin
            st_d.tx_data = {st_q.tx_s3.txd, st_q.tx_s3.en, st_q.tx_s3.er};
            st_d.tx_valid = 1'b1;
            st_d.tx_err = 1'b0;
         end
         else
         begin
            st_d.tx_valid = st_q.tx_s3.en;
            st_d.tx_data = {2'h0, gmii_port_pkg::mask_data(mode, st_q.tx_s3.txd)};
            st_d.tx_err = st_q.tx_s3.en && st_q.tx_s3.er &&
                          (mode == gmii_port_pkg::MODE_GIG || mode == gmii_port_pkg::MODE_FAST);
            // Extension only follows the frame: enable low with error high
            st_d.tx_ext = !st_q.tx_s3.en && st_q.tx_s3.er && !st_q.fdx &&
                          (mode == gmii_port_pkg::MODE_GIG);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign rbc1_lvl = st_q.done && (st_q.rx_cnt < rx_hi);
   assign link.tx_clk = st_q.done && (st_q.tx_cnt < (tx_per >> 1));
   // Ten-bit mode reuses the collision pin for the first byte clock and the rx clock pin for the second
   assign link.rx_clk = st_q.tbi ? (st_q.done && !rbc1_lvl) : rbc1_lvl;
   assign link.col = st_q.tbi ? rbc1_lvl :
                     (st_q.done && line_collision_i && !st_q.fdx);
   assign link.crs = st_q.tbi ? st_q.comma : (st_q.done && line_activity_i);
   assign link.rxd = st_q.rxd;
   assign link.rx_dv = st_q.dv;
   assign link.rx_er = st_q.er;
   assign line_rx_take_o = rx_upd;
   assign line_tx_valid_o = st_q.tx_valid;
   assign line_tx_data_o = st_q.tx_data;
   assign line_tx_err_o = st_q.tx_err;
   assign line_tx_ext_o = st_q.tx_ext;

endmodule
`default_nettype wire

// ==== logic/gmii_mac_end.sv ====
// Controller end of the MAC data port with an APB register slave
`timescale 1ns/1ps
`default_nettype none
module gmii_mac_end (
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   input  wire logic                             psel_i,
   input  wire logic                             penable_i,
   input  wire logic                             pwrite_i,
   input  wire logic [gmii_port_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]                      pwdata_i,
   output logic [31:0]                           prdata_o,
   output logic                                  pready_o,
   output logic                                  pslverr_o,
   gmii_link_if.mac                              link
);

   typedef struct packed {
      gmii_port_pkg::mac_in_t               s1;
      gmii_port_pkg::mac_in_t               s2;
      gmii_port_pkg::mac_in_t               s3;
      logic [2:0]                           lvl;
      logic [3:0]                           ctrl;
      logic [9:0]                           txw;
      logic                                 tx_pend;
      logic [9:0]                           rxw;
      logic                                 rx_full;
      logic                                 rx_ovr;
      logic [gmii_port_pkg::CNT_W-1:0]      gtx_cnt;
      logic [7:0]                           txd;
      logic                                 tx_en;
      logic                                 tx_er;
      logic [31:0]                          prdata;
   } state_t;

   localparam state_t RESET_ST = '{ctrl: gmii_port_pkg::CTRL_RST, default: '0};

   state_t                                  st_q;
   state_t                                  st_d;
   gmii_port_pkg::mode_t                    mode;
   logic                                    tbi;
   logic                                    gig_clocked;
   logic                                    mapped;

   assign tbi = st_q.ctrl[gmii_port_pkg::CTRL_TBI_BIT];
   assign mode = gmii_port_pkg::mode_of(tbi, st_q.ctrl[gmii_port_pkg::CTRL_SER_BIT],
                                        st_q.ctrl[1:0]);
   assign gig_clocked = (mode == gmii_port_pkg::MODE_GIG) || (mode == gmii_port_pkg::MODE_TBI);
   assign mapped = (paddr_i == gmii_port_pkg::CTRL_OFS) || (paddr_i == gmii_port_pkg::STAT_OFS)
                || (paddr_i == gmii_port_pkg::TXW_OFS) || (paddr_i == gmii_port_pkg::RXW_OFS);

   always_comb
   begin
      logic [2:0] c2;
      logic [2:0] c3;
      logic [2:0] stb;
      logic [2:0] rise;
      logic       drive;
      logic       cap;
      c2 = {st_q.s2.tx_clk, st_q.s2.rx_clk, st_q.s2.col};
      c3 = {st_q.s3.tx_clk, st_q.s3.rx_clk, st_q.s3.col};
      stb = ~(c2 ^ c3);
      rise = stb & c3 & ~st_q.lvl;
      st_d = st_q;
      st_d.s1 = {link.tx_clk, link.rx_clk, link.col, link.crs,
                 link.rx_er, link.rx_dv, link.rxd};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.lvl = (stb & c3) | (~stb & st_q.lvl);

      // Gigabit clock is made here; 10/100 data follows the transceiver's tx clock
      st_d.gtx_cnt = (gig_clocked && st_q.gtx_cnt < gmii_port_pkg::GIG_PER - gmii_port_pkg::CNT_ONE)
                     ? st_q.gtx_cnt + gmii_port_pkg::CNT_ONE : '0;
      drive = gig_clocked ? (st_q.gtx_cnt == (gmii_port_pkg::GIG_PER >> 1)) : rise[2];
      if (drive)
      begin
         st_d.tx_pend = 1'b0;
         if (!st_q.tx_pend)
            {st_d.txd, st_d.tx_en, st_d.tx_er} = 10'h000;
         else if (tbi)
            {st_d.txd, st_d.tx_en, st_d.tx_er} = st_q.txw;
         else
         begin
            st_d.txd = st_q.txw[7:0];
            st_d.tx_en = st_q.txw[gmii_port_pkg::WORD_EN];
            st_d.tx_er = st_q.txw[gmii_port_pkg::WORD_ER];
         end
      end

      // Setup phase latches read data so it is stable through the access phase
      if (psel_i && !penable_i)
      begin
         unique case (paddr_i)
            gmii_port_pkg::CTRL_OFS: st_d.prdata = {28'h0000000, st_q.ctrl};
            gmii_port_pkg::STAT_OFS: st_d.prdata = {27'h0000000, st_q.s3.crs, st_q.s3.col,
                                                    st_q.rx_ovr, st_q.rx_full, st_q.tx_pend};
            gmii_port_pkg::RXW_OFS:  st_d.prdata = {22'h000000, st_q.rxw};
            default:                 st_d.prdata = 32'h00000000;
         endcase
      end

      // Software clears come first so a same-cycle hardware event wins
      if (psel_i && penable_i && mapped)
      begin
         if (pwrite_i && paddr_i == gmii_port_pkg::CTRL_OFS)
            st_d.ctrl = pwdata_i[3:0];
         if (pwrite_i && paddr_i == gmii_port_pkg::TXW_OFS)
         begin
            st_d.txw = pwdata_i[9:0];
            st_d.tx_pend = 1'b1;
         end
         if (pwrite_i && paddr_i == gmii_port_pkg::STAT_OFS && pwdata_i[gmii_port_pkg::ST_OVR])
            st_d.rx_ovr = 1'b0;
         if (!pwrite_i && paddr_i == gmii_port_pkg::RXW_OFS)
            st_d.rx_full = 1'b0;
      end

      cap = tbi ? (rise[1] || rise[0]) : (rise[1] && (st_q.s3.dv || st_q.s3.er));
      if (cap)
      begin
         if (st_q.rx_full)
            st_d.rx_ovr = 1'b1;
         else
         begin
            st_d.rx_full = 1'b1;
            st_d.rxw = tbi ? {st_q.s3.rxd, st_q.s3.dv, st_q.s3.er}
                           : {st_q.s3.er, st_q.s3.dv, st_q.s3.rxd};
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         st_q <= RESET_ST;
      else
         st_q <= st_d;
   end

   assign link.gtx_clk = gig_clocked && (st_q.gtx_cnt < (gmii_port_pkg::GIG_PER >> 1));
   assign link.txd = st_q.txd;
   assign link.tx_en = st_q.tx_en;
   assign link.tx_er = st_q.tx_er;
   assign prdata_o = st_q.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

endmodule
`default_nettype wire

// ==== tb/gmii_link_assertions.sv ====
// Checker on the wires between the two ends of the MAC data port
`timescale 1ns/1ps
`default_nettype none
module gmii_link_assertions (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] txd,
   input wire logic       tx_en,
   input wire logic       tx_er,
   input wire logic       gtx_clk,
   input wire logic       tx_clk,
   input wire logic [7:0] rxd,
   input wire logic       rx_dv,
   input wire logic       rx_er,
   input wire logic       rx_clk,
   input wire logic       col,
   input wire logic       tbi
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rx_quiet;
      disable iff (1'b0) rst_i |-> (rxd == 8'h00) && !rx_dv && !rx_er;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet)
      else $error("rx pins active in reset");
   // Rx pins may only move while their clock is low; ten-bit codes may also move while the first byte clock is low
   property p_rx_at_low;
      $changed({rxd, rx_dv, rx_er}) |-> !rx_clk || (tbi && !col);
   endproperty
   a_rx_at_low: assert property (p_rx_at_low)
      else $error("rx pins moved while rx clock high");
   property p_rxc_high;
      $rose(rx_clk) |=> rx_clk [*3];
   endproperty
   a_rxc_high: assert property (p_rxc_high)
      else $error("rx clock high phase too short");
   property p_rxc_low;
      $fell(rx_clk) |=> !rx_clk [*3];
   endproperty
   a_rxc_low: assert property (p_rxc_low)
      else $error("rx clock low phase too short");
   property p_txc_high;
      $rose(tx_clk) |=> tx_clk [*8];
   endproperty
   a_txc_high: assert property (p_txc_high)
      else $error("tx clock high phase too short");
   property p_txc_low;
      $fell(tx_clk) |=> !tx_clk [*8];
   endproperty
   a_txc_low: assert property (p_txc_low)
      else $error("tx clock low phase too short");
   property p_tx_gtx;
      $changed({txd, tx_en, tx_er}) |-> !gtx_clk;
   endproperty
   a_tx_gtx: assert property (p_tx_gtx)
      else $error("tx pins moved while gigabit clock high");
   property p_tx_hold;
      $changed({txd, tx_en, tx_er}) |=> $stable({txd, tx_en, tx_er}) [*3];
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx pins not held for a symbol");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Testbench joining both ends of the MAC data port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tbi_s = 1'b0;
   logic        man_s = 1'b0;
   logic [1:0]  spd = 2'h2;
   logic        fdx = 1'b1;
   logic        lrv = 1'b0;
   logic [9:0]  lrd = 10'h000;
   logic        lre = 1'b0;
   logic        lcol = 1'b0;
   logic        lact = 1'b0;
   logic        tv;
   logic [9:0]  td;
   logic        te;
   logic [31:0] rd;
   logic        er;
   logic        c;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   gmii_link_if link ();
   always #50 clk = ~clk;
   gmii_phy_end u_gmii_phy_end (.clk_i(clk), .rst_i(rst), .link(link),
      .ten_bit_select_i(tbi_s), .ten_meg_serial_select_i(1'b0), .manual_select_i(man_s),
      .speed_select_i(spd), .full_duplex_select_i(fdx), .line_rx_valid_i(lrv),
      .line_rx_data_i(lrd), .line_rx_err_i(lre), .line_rx_ext_i(1'b0), .line_rx_take_o(),
      .line_collision_i(lcol), .line_activity_i(lact), .line_tx_valid_o(tv),
      .line_tx_data_o(td), .line_tx_err_o(te), .line_tx_ext_o());
   gmii_mac_end u_gmii_mac_end (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .link(link));
   gmii_link_assertions u_chk (.clk_i(clk), .rst_i(rst), .txd(link.txd), .tx_en(link.tx_en),
      .tx_er(link.tx_er), .gtx_clk(link.gtx_clk), .tx_clk(link.tx_clk), .rxd(link.rxd),
      .rx_dv(link.rx_dv), .rx_er(link.rx_er), .rx_clk(link.rx_clk), .col(link.col),
      .tbi(u_gmii_phy_end.st_q.tbi));
   task automatic conclude();
      $display("compared %0d, mismatched %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Word goes out through the controller; the line side of the device must show it
   task automatic send(input logic [31:0] w, input logic [31:0] ed, input logic ee);
      int i;
      apb(1'b1, gmii_port_pkg::TXW_OFS, w);
      i = 0;
      while (tv !== 1'b1 && i < 2000)
      begin
         @(negedge clk);
         i++;
      end
      check("tx seen", {31'h0, tv}, 32'h1);
      check("tx data", {22'h0, td}, ed);
      check("tx err", {31'h0, te}, {31'h0, ee});
   endtask
   // Line symbol comes in; long settle so no captured word is still in flight
   task automatic recv(input logic [9:0] d, input logic e, input logic [31:0] ew);
      int i;
      @(posedge clk);
      lrd <= d;
      lre <= e;
      lrv <= 1'b1;
      i = 0;
      rd = 32'h0;
      while (rd[gmii_port_pkg::ST_RXF] !== 1'b1 && i < 500)
      begin
         apb(1'b0, gmii_port_pkg::STAT_OFS, 32'h0);
         i++;
      end
      check("rx full", {31'h0, rd[gmii_port_pkg::ST_RXF]}, 32'h1);
      lrv <= 1'b0;
      repeat (1000) @(posedge clk);
      apb(1'b0, gmii_port_pkg::RXW_OFS, 32'h0);
      check("rx word", rd, ew);
   endtask
   task automatic pins(input logic c, input logic a, input logic f, input logic ec);
      @(posedge clk);
      lcol <= c;
      lact <= a;
      fdx <= f;
      repeat (60) @(posedge clk);
      @(negedge clk);
      check("col", {31'h0, link.col}, {31'h0, ec});
      check("crs", {31'h0, link.crs}, {31'h0, a});
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      tbi_s <= 1'b1;
      spd <= 2'h0;
      apb(1'b0, gmii_port_pkg::CTRL_OFS, 32'h0);
      check("ctrl reset", rd, 32'h2);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped err", {31'h0, er}, 32'h1);
      check("unmapped data", rd, 32'h0);
      send(32'h1A5, 32'h0A5, 1'b0);
      recv(10'h3C3, 1'b0, 32'h1C3);
      $display("gigabit test done");
      man_s <= 1'b1;
      spd <= 2'h1;
      fdx <= 1'b0;
      apb(1'b1, gmii_port_pkg::CTRL_OFS, 32'h1);
      repeat (200) @(posedge clk);
      send(32'h3A5, 32'h005, 1'b1);
      recv(10'h0FF, 1'b0, 32'h10F);
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      pins(1'b1, 1'b0, 1'b1, 1'b0);
      $display("100 Mbps test done");
      spd <= 2'h0;
      apb(1'b1, gmii_port_pkg::CTRL_OFS, 32'h0);
      repeat (1000) @(posedge clk);
      send(32'h3A5, 32'h005, 1'b0);
      recv(10'h0FF, 1'b1, 32'h10F);
      $display("10 Mbps test done");
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      lrd <= 10'h3E5;
      repeat (20) @(posedge clk);
      apb(1'b1, gmii_port_pkg::CTRL_OFS, 32'hA);
      apb(1'b0, gmii_port_pkg::RXW_OFS, 32'h0);
      recv(10'h3E5, 1'b0, 32'h3E5);
      @(negedge clk);
      c = link.crs;
      repeat (8) @(negedge clk);
      check("comma", {31'h0, link.crs}, {31'h0, !c});
      $display("ten-bit test done");
      conclude();
   end
   // Whole run is near 7000 cycles; this limit leaves ample margin
   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
